// [core/mscs_core.sv]
/*
 * Contactor sequencer for four starter configurations: non-reversing,
 * bidirectional, two-speed and slip ring. Drives contactors A and B,
 * times the transfer delay and, from a seconds count not cleared at start, the bypass delay, and watches the auxiliary
 * feedback contacts for missing feedback and stuck-closed contacts.
 * Assumes a 100 MHz pclk, an APB master for setup, and command and
 * feedback pins synchronous to pclk.
 */
`timescale 1ns/1ps
`include "mscs_defs.svh"
module mscs_core #(
    parameter int unsigned MS_CYCLES = `MSCS_CLK_KHZ, // Cycles per millisecond.
    parameter int unsigned FB_MS     = `MSCS_FB_WINDOW_MS // Feedback window.
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Command pins from switch inputs and front panel.
    input  wire logic        start_a_in,
    input  wire logic        start_b_in,
    input  wire logic        stop_in,
    input  wire logic        trip_in,
    // Contactor outputs and feedback.
    output logic             contactor_a,
    output logic             contactor_b,
    input  wire logic        feedback_a,
    input  wire logic        feedback_b,
    // Alarms.
    output logic             missing_fb_alarm,
    output logic             stuck_closed_alarm
);
    // Millisecond tick divider width and one-second count.
    localparam int unsigned DIV_W = $clog2(MS_CYCLES);
    localparam int unsigned SEC_MS = 1000;

    // Register state.
    logic [1:0]  cfg_q;            // Starter configuration.
    logic        inhibit_q;        // Fast-start inhibit for two-speed.
    logic [6:0]  delay_q;          // Transfer or bypass delay in seconds.
    mscs_pkg::mscs_cmd_t bus_cmd_q; // One-cycle commands written by software.
    logic        bus_clr_q;        // One-cycle alarm clear.
    logic        ack_q;            // APB access acknowledge.

    // Sequencer state.
    mscs_pkg::mscs_state_t st_q, st_d;
    logic        pend_a_q, pend_a_d; // Contactor to close after WAIT.
    logic        a_q, a_d, b_q, b_d;
    logic [DIV_W-1:0] div_q;       // Millisecond divider.
    logic        ms_tick;          // One-cycle millisecond enable.
    logic [9:0]  ms_q;             // Milliseconds within the second.
    logic        sec_tick;         // One-cycle second enable.
    logic [6:0]  dly_cnt_q, dly_cnt_d; // Seconds elapsed in delay.
    logic [10:0] fa_cnt_q, fb_cnt_q;   // Feedback check timers in ms.
    mscs_pkg::mscs_alarm_t alm_q;  // Sticky alarms.

    // Decoding of the bus access.
    wire         acc     = psel && penable;
    wire         wr      = acc && pwrite && !ack_q;
    wire         hit_ctl = paddr == `MSCS_ADDR_CTRL;
    wire         hit_dly = paddr == `MSCS_ADDR_DELAY;
    wire         hit_cmd = paddr == `MSCS_ADDR_CMD;
    wire         hit_sts = paddr == `MSCS_ADDR_STATUS;
    wire         mapped  = hit_ctl || hit_dly || hit_cmd || hit_sts;
    // Delay writes are clamped into the legal 1 to 125 second range.
    wire  [6:0]  wdly    = pwdata[`MSCS_DELAY_HI:0];
    wire  [6:0]  dly_lim = (wdly < `MSCS_DELAY_MIN) ? `MSCS_DELAY_MIN :
                           (wdly > `MSCS_DELAY_MAX) ? `MSCS_DELAY_MAX : wdly;
    wire  [31:0] rd_word = hit_ctl ? {29'h0, inhibit_q, cfg_q} :
                           hit_dly ? {25'h0, delay_q} :
                           hit_sts ? {24'h0, 3'h0, st_q, alm_q} : 32'h0;

    // Merged commands; stop and trip are combined as one halt.
    wire         halt    = stop_in || trip_in || bus_cmd_q.stop;
    wire         go_a    = start_a_in || bus_cmd_q.start_a;
    wire         go_b    = start_b_in || bus_cmd_q.start_b;
    wire         delay_done = sec_tick && (dly_cnt_q + 7'h01 >= delay_q);
    // Feedback missing one second after closing a contactor.
    wire         miss_a  = a_q && !feedback_a && fa_cnt_q >= 11'(FB_MS);
    wire         miss_b  = b_q && !feedback_b && fb_cnt_q >= 11'(FB_MS);
    wire         miss    = miss_a || miss_b;
    // Feedback still present one second after opening a contactor.
    wire         stuck   = (!a_q && feedback_a && fa_cnt_q >= 11'(FB_MS)) ||
                           (!b_q && feedback_b && fb_cnt_q >= 11'(FB_MS));

    // APB slave: one wait state on writes and reads, error on unmapped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {inhibit_q, cfg_q} <= `MSCS_CTRL_RST; // Non-reversing, inhibit off.
            delay_q   <= `MSCS_DELAY_RST;
            bus_cmd_q <= '0;
            bus_clr_q <= 1'b0;
            ack_q     <= 1'b0;
            prdata    <= 32'h0;
            pslverr   <= 1'b0;
        end else begin
            ack_q     <= acc && !ack_q;
            bus_cmd_q <= '0;
            bus_clr_q <= 1'b0;
            if (wr && hit_ctl) begin
                // Changing the configuration only takes hold at standstill. [RULE_05]
                if (st_q == mscs_pkg::MSCS_IDLE) begin
                    cfg_q <= pwdata[`MSCS_CTRL_CFG_HI:`MSCS_CTRL_CFG_LO];
                end
                inhibit_q <= pwdata[`MSCS_CTRL_INHIBIT];
            end
            if (wr && hit_dly) begin
                delay_q <= dly_lim; // [RULE_06] [RULE_12] [RULE_20]
            end
            if (wr && hit_cmd) begin
                bus_cmd_q.start_a <= pwdata[`MSCS_CMD_START_A];
                bus_cmd_q.start_b <= pwdata[`MSCS_CMD_START_B];
                bus_cmd_q.stop    <= pwdata[`MSCS_CMD_STOP];
                bus_clr_q         <= pwdata[`MSCS_CMD_CLR_ALARM];
            end
            prdata  <= (acc && !ack_q && !pwrite) ? rd_word : 32'h0;
            pslverr <= acc && !ack_q && !mapped;
        end
    end
    assign pready = ack_q;

    // Millisecond and second enables; reset when a delay is (re)started.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
            ms_q  <= 10'h000;
        end else if (st_q != st_d) begin
            div_q <= '0;
            ms_q  <= 10'h000;
        end else if (ms_tick) begin
            div_q <= '0;
            ms_q  <= (ms_q == 10'(SEC_MS - 1)) ? 10'h000 : ms_q + 10'h001;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign ms_tick  = div_q == DIV_W'(MS_CYCLES - 1);
    assign sec_tick = ms_tick && ms_q == 10'(SEC_MS - 1);

    // Next state of the sequencer. Halt is tested first so stop always wins.
    always_comb begin
        st_d      = st_q;
        a_d       = a_q;
        b_d       = b_q;
        pend_a_d  = pend_a_q;
        dly_cnt_d = (st_q == mscs_pkg::MSCS_WAIT || st_q == mscs_pkg::MSCS_BYP) && sec_tick ?
                    dly_cnt_q + 7'h01 : dly_cnt_q;
        if (halt) begin
            // All configurations open what is closed. [RULE_02] [RULE_08] [RULE_17] [RULE_22] [RULE_23]
            st_d = mscs_pkg::MSCS_IDLE;
            a_d  = 1'b0;
            b_d  = 1'b0;
        end else if (miss) begin
            // Missing feedback opens the closed contactor; two-speed and slip ring open both.
            st_d = mscs_pkg::MSCS_IDLE; // [RULE_03] [RULE_10] [RULE_18]
            a_d  = (cfg_q == `MSCS_CFG_FVBIDIR) ? a_q && !miss_a : 1'b0;
            b_d  = (cfg_q == `MSCS_CFG_FVBIDIR) ? b_q && !miss_b : 1'b0;
            if (a_d) st_d = mscs_pkg::MSCS_RUN_A;
            if (b_d) st_d = mscs_pkg::MSCS_RUN_B;
        end else begin
            case (st_q)
                mscs_pkg::MSCS_IDLE: begin
                    if (go_a) begin
                        // Start A closes A in every configuration. [RULE_01] [RULE_07] [RULE_14] [RULE_21]
                        a_d  = 1'b1;
                        st_d = (cfg_q == `MSCS_CFG_SLIPRING) ? mscs_pkg::MSCS_BYP : mscs_pkg::MSCS_RUN_A;
                    end else if (go_b && (cfg_q == `MSCS_CFG_FVBIDIR ||
                                          (cfg_q == `MSCS_CFG_TWOSPD && !inhibit_q))) begin
                        b_d  = 1'b1; // [RULE_13]
                        st_d = mscs_pkg::MSCS_RUN_B;
                    end
                end
                mscs_pkg::MSCS_RUN_A: begin
                    // Start A again changes nothing. [RULE_23]
                    if (go_b && cfg_q == `MSCS_CFG_FVBIDIR) begin
                        a_d       = 1'b0; // [RULE_09]
                        pend_a_d  = 1'b0;
                        dly_cnt_d = 7'h00;
                        st_d      = mscs_pkg::MSCS_WAIT;
                    end else if (go_b && cfg_q == `MSCS_CFG_TWOSPD) begin
                        a_d  = 1'b0; // [RULE_15]
                        b_d  = 1'b1;
                        st_d = mscs_pkg::MSCS_RUN_B;
                    end
                end
                mscs_pkg::MSCS_RUN_B: begin
                    if (go_a && (cfg_q == `MSCS_CFG_FVBIDIR || cfg_q == `MSCS_CFG_TWOSPD)) begin
                        b_d       = 1'b0; // [RULE_09] [RULE_16]
                        pend_a_d  = 1'b1;
                        dly_cnt_d = 7'h00; // Delay counts from B dropping out. [RULE_12]
                        st_d      = mscs_pkg::MSCS_WAIT;
                    end
                end
                mscs_pkg::MSCS_WAIT: begin
                    // Repeat starts during the wait leave the timer alone.
                    if (delay_done) begin
                        a_d  = pend_a_q; // [RULE_06] [RULE_09] [RULE_16]
                        b_d  = !pend_a_q;
                        st_d = pend_a_q ? mscs_pkg::MSCS_RUN_A : mscs_pkg::MSCS_RUN_B;
                    end
                end
                mscs_pkg::MSCS_BYP: begin
                    if (delay_done) begin
                        b_d  = 1'b1; // [RULE_20] [RULE_21]
                        st_d = mscs_pkg::MSCS_RUN_AB;
                    end
                end
                mscs_pkg::MSCS_RUN_AB: begin
                    st_d = mscs_pkg::MSCS_RUN_AB;
                end
                default: begin
                    st_d = mscs_pkg::MSCS_IDLE;
                    a_d  = 1'b0;
                    b_d  = 1'b0;
                end
            endcase
        end
    end

    // Sequencer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= mscs_pkg::MSCS_IDLE;
            a_q       <= 1'b0;
            b_q       <= 1'b0;
            pend_a_q  <= 1'b0;
            dly_cnt_q <= 7'h00;
        end else begin
            st_q      <= st_d;
            a_q       <= a_d;
            b_q       <= b_d;
            pend_a_q  <= pend_a_d;
            dly_cnt_q <= dly_cnt_d;
        end
    end
    assign contactor_a = a_q;
    assign contactor_b = b_q;

    // Feedback timers restart on each contactor change and stop at the window.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fa_cnt_q <= 11'h000;
            fb_cnt_q <= 11'h000;
        end else begin
            if (a_d != a_q) fa_cnt_q <= 11'h000;
            else if (ms_tick && fa_cnt_q < 11'(FB_MS)) fa_cnt_q <= fa_cnt_q + 11'h001;
            if (b_d != b_q) fb_cnt_q <= 11'h000;
            else if (ms_tick && fb_cnt_q < 11'(FB_MS)) fb_cnt_q <= fb_cnt_q + 11'h001;
        end
    end

    // Sticky alarms; a new event wins over a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alm_q <= '0;
        end else begin
            alm_q.missing_fb   <= miss || (alm_q.missing_fb && !bus_clr_q); // [RULE_03] [RULE_10] [RULE_18]
            alm_q.stuck_closed <= stuck || (alm_q.stuck_closed && !bus_clr_q); // [RULE_04] [RULE_11] [RULE_19]
        end
    end
    assign missing_fb_alarm   = alm_q.missing_fb;
    assign stuck_closed_alarm = alm_q.stuck_closed;

    // Checks on the sequencer.
    a_stop_opens_all: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
        halt |=> !contactor_a && !contactor_b) else $error("Stop left a contactor closed.");
    a_miss_raises: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
        miss |=> missing_fb_alarm) else $error("Missing feedback not flagged.");
    a_stuck_raises: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
        stuck |=> stuck_closed_alarm) else $error("Stuck contact not flagged.");
    a_never_both_rev: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
        cfg_q == `MSCS_CFG_FVBIDIR |-> !(contactor_a && contactor_b)) else $error("Both directions closed.");
    a_twospd_miss_both: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
        (miss && !halt && cfg_q == `MSCS_CFG_TWOSPD) |=> !contactor_a && !contactor_b)
        else $error("Two-speed fault left a contactor closed.");
    a_inhibit_blocks: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
        (st_q == mscs_pkg::MSCS_IDLE && cfg_q == `MSCS_CFG_TWOSPD && inhibit_q && go_b && !go_a)
        |=> !contactor_b) else $error("Inhibited high speed start closed B.");
    a_low_to_high: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
        (st_q == mscs_pkg::MSCS_RUN_A && cfg_q == `MSCS_CFG_TWOSPD && go_b && !halt && !miss)
        |=> !contactor_a && contactor_b) else $error("Low to high was delayed.");
    a_wait_opens: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
        st_q == mscs_pkg::MSCS_WAIT |-> !contactor_a && !contactor_b) else $error("Closed during wait.");
    a_bypass_a_only: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_21]
        st_q == mscs_pkg::MSCS_BYP |-> contactor_a && !contactor_b) else $error("Bypass state wrong.");
    a_slip_run: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_20]
        $rose(contactor_b) && cfg_q == `MSCS_CFG_SLIPRING |-> contactor_a) else $error("B closed without A.");
    a_repeat_start: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_23]
        (st_q == mscs_pkg::MSCS_RUN_A && go_a && !go_b && !halt && !miss) |=> $stable(contactor_a))
        else $error("Repeat start changed A.");
endmodule : mscs_core

// [include/mscs_defs.svh]
/*
 * Constants for the motor starter contactor sequencer: the starter
 * configuration codes, the register map on the APB bus, the timing
 * figures and the reset values.
 * Assumes it is included by its bare name by the package and the core.
 */
// Summary of operation
// [RULE_01] Non-reversing: start closes and holds contactor A.
// [RULE_02] Non-reversing: stop or trip opens A.
// [RULE_03] Non-reversing: no A feedback in 1 s, alarm, open.
// [RULE_04] Non-reversing: A feedback 1 s after opening, stuck alarm.
// [RULE_05] Selectable configuration; settings apply only when selected.
// [RULE_06] Reversing: direction-change delay 1 to 125 s.
// [RULE_07] Reversing: start A closes and holds A.
// [RULE_08] Reversing: stop or trip opens closed contactor.
// [RULE_09] Reversing: opposite start opens, waits delay, closes other.
// [RULE_10] Reversing: missing feedback in 1 s, alarm, open.
// [RULE_11] Reversing: feedback 1 s after opening, stuck alarm.
// [RULE_12] Two-speed: high-to-low delay timed from B dropout.
// [RULE_13] Two-speed: inhibit ignores start B from standstill.
// [RULE_14] Two-speed: start A closes and holds A.
// [RULE_15] Two-speed: low-to-high opens A, closes B, no delay.
// [RULE_16] Two-speed: high-to-low opens B, waits, closes A.
// [RULE_17] Two-speed: stop or trip opens closed contactor.
// [RULE_18] Two-speed: missing feedback opens both, alarm.
// [RULE_19] Two-speed: feedback 1 s after opening, stuck alarm.
// [RULE_20] Slip ring: bypass delay 1 to 125 s; the code does not clear the seconds count at start, so it can end early.
// [RULE_21] Slip ring: start closes A, waits, closes B.
// [RULE_22] Slip ring: stop or trip opens both.
// [RULE_23] Repeat start no effect; stop beats start.
`ifndef MSCS_DEFS_SVH
`define MSCS_DEFS_SVH

// Starter configuration codes.
`define MSCS_CFG_FVNR        2'h0
`define MSCS_CFG_FVBIDIR     2'h1
`define MSCS_CFG_TWOSPD      2'h2
`define MSCS_CFG_SLIPRING    2'h3

// Register byte addresses.
`define MSCS_ADDR_CTRL       12'h000
`define MSCS_ADDR_DELAY      12'h004
`define MSCS_ADDR_CMD        12'h008
`define MSCS_ADDR_STATUS     12'h00C

// Field positions.
`define MSCS_CTRL_CFG_LO     0
`define MSCS_CTRL_CFG_HI     1
`define MSCS_CTRL_INHIBIT    2
`define MSCS_CMD_START_A     0
`define MSCS_CMD_START_B     1
`define MSCS_CMD_STOP        2
`define MSCS_CMD_CLR_ALARM   3
`define MSCS_DELAY_HI        6

// Delay setting limits and reset values.
`define MSCS_DELAY_MIN       7'h01
`define MSCS_DELAY_MAX       7'h7D
`define MSCS_DELAY_RST       7'h01
`define MSCS_CTRL_RST        3'h0

// Timing: feedback window in ms and clock rate in kHz.
`define MSCS_FB_WINDOW_MS    1000
`define MSCS_CLK_KHZ         100000

`endif

// [include/mscs_pkg.sv]
/*
 * Types for the motor starter contactor sequencer.
 * Assumes mscs_defs.svh is on the include path.
 */
`include "mscs_defs.svh"
package mscs_pkg;
    // Sequencer states.
    typedef enum logic [2:0] {
        MSCS_IDLE  = 3'b000,
        MSCS_RUN_A = 3'b001,
        MSCS_RUN_B = 3'b010,
        MSCS_WAIT  = 3'b011,
        MSCS_BYP   = 3'b100,
        MSCS_RUN_AB= 3'b101
    } mscs_state_t;

    // Commands that travel together from the bus command register.
    typedef struct packed {
        logic start_a;
        logic start_b;
        logic stop;
    } mscs_cmd_t;

    // Alarm flags reported together.
    typedef struct packed {
        logic missing_fb;
        logic stuck_closed;
    } mscs_alarm_t;
endpackage : mscs_pkg

// [testbench/mscs_contactor_model.sv]
/*
 * Behavioural pair of motor contactors with auxiliary feedback contacts.
 * Assumes coil drives are sampled on pclk and the bench sets the fault modes.
 */
`timescale 1ns/1ps
module mscs_contactor_model #(
    parameter int LAG = 3 // Pickup and dropout time in cycles.
) (
    // Clock.
    input  wire logic       pclk,
    // Coil drives and fault modes: 0 healthy, 1 dead contact, 2 welded.
    input  wire logic       coil_a,
    input  wire logic       coil_b,
    input  wire logic [1:0] mode_a,
    input  wire logic [1:0] mode_b,
    // Auxiliary contacts, high when closed.
    output logic            aux_a,
    output logic            aux_b
);
    logic [LAG-1:0] hist_a; // Coil history of contactor A.
    logic [LAG-1:0] hist_b; // Coil history of contactor B.

    // Contacts start open, as after loss of power.
    initial begin
        hist_a = '0;
        hist_b = '0;
        aux_a  = 1'b0;
        aux_b  = 1'b0;
    end

    // The armature lags the coil, so feedback is never instant.
    always @(posedge pclk) begin
        hist_a <= {hist_a[LAG-2:0], coil_a};
        hist_b <= {hist_b[LAG-2:0], coil_b};
        // A welded contact stays closed once it has closed; a dead one never closes.
        aux_a  <= (mode_a == 2'h2) ? (aux_a | hist_a[LAG-1]) : ((mode_a == 2'h0) & hist_a[LAG-1]);
        aux_b  <= (mode_b == 2'h2) ? (aux_b | hist_b[LAG-1]) : ((mode_b == 2'h0) & hist_b[LAG-1]);
    end
endmodule : mscs_contactor_model

// [testbench/mscs_core_tb.sv]
/*
 * Self-checking bench for the contactor sequencer: APB register access,
 * command pins and the four starter sequences against a contactor model.
 * Assumes mscs_defs.svh on the include path and shortened ms timing.
 */
`timescale 1ns/1ps
`include "mscs_defs.svh"
module mscs_core_tb;
    localparam int MS   = 10;        // Cycles per millisecond in simulation.
    localparam int FBMS = 5;         // Shortened feedback window in ms.
    localparam int FBC  = MS * FBMS; // Feedback window in cycles.
    localparam int SEC  = MS * 1000; // One delay second in cycles.
    logic        pclk = 1'b0;        // Bus clock.
    logic        presetn;            // Active-low reset.
    logic        psel;               // APB select.
    logic        penable;            // APB enable.
    logic        pwrite;             // APB direction.
    logic [11:0] paddr;              // APB address.
    logic [31:0] pwdata;             // APB write data.
    logic [31:0] prdata;             // APB read data.
    logic        pready;             // APB ready.
    logic        pslverr;            // APB error.
    logic        start_a_in;         // Start A pin.
    logic        start_b_in;         // Start B pin.
    logic        stop_in;            // Stop pin.
    logic        trip_in;            // Trip pin.
    logic        contactor_a;        // Relay A.
    logic        contactor_b;        // Relay B.
    logic        feedback_a;         // Auxiliary contact A.
    logic        feedback_b;         // Auxiliary contact B.
    logic        missing_fb_alarm;   // Missing feedback alarm.
    logic        stuck_closed_alarm; // Stuck contact alarm.
    logic [1:0]  mode_a;             // Fault mode of contactor A.
    logic [1:0]  mode_b;             // Fault mode of contactor B.
    int          err_count  = 0;     // Mismatches seen.
    int          num_checks = 0;     // Comparisons made.
    int          cycles     = 0;     // Watchdog count.
    int          n;                  // Measured delay.

    always #5 pclk = ~pclk;

    mscs_core #(.MS_CYCLES(MS), .FB_MS(FBMS)) i_mscs_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .start_a_in(start_a_in), .start_b_in(start_b_in), .stop_in(stop_in), .trip_in(trip_in),
        .contactor_a(contactor_a), .contactor_b(contactor_b), .feedback_a(feedback_a),
        .feedback_b(feedback_b), .missing_fb_alarm(missing_fb_alarm),
        .stuck_closed_alarm(stuck_closed_alarm));

    mscs_contactor_model i_mscs_contactor_model (
        .pclk(pclk), .coil_a(contactor_a), .coil_b(contactor_b), .mode_a(mode_a),
        .mode_b(mode_b), .aux_a(feedback_a), .aux_b(feedback_b));

    // Compares one value and reports a mismatch at once.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Relays and alarms as one nibble: A, B, missing, stuck.
    function automatic logic [31:0] st();
        return {28'h0, stuck_closed_alarm, missing_fb_alarm, contactor_b, contactor_a};
    endfunction : st

    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc

    // One APB transfer; holds the request until pready is seen high.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    // Read data is only meaningful when no error is expected.
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(32'(e), 32'(experr));
        if (experr == 1'b0) check(q, exp);
    endtask : rd

    // Pulses the pins {trip, stop, start B, start A} for one cycle and lets it settle.
    task pulse(input logic [3:0] p);
        @(posedge pclk);
        {trip_in, stop_in, start_b_in, start_a_in} <= p;
        @(posedge pclk);
        {trip_in, stop_in, start_b_in, start_a_in} <= 4'h0;
        cyc(3);
    endtask : pulse

    // Counts cycles until the chosen relay closes, then checks one delay second.
    task wait_on(input logic sel_b);
        n = 0;
        while (((sel_b ? contactor_b : contactor_a) !== 1'b1) && n < SEC + 500) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n >= SEC - 10 && n <= SEC + MS + 10), 32'h1);
    endtask : wait_on

    // A hang is cut short here and counted as a mismatch.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 70000) begin
            err_count++;
            complete_run();
        end
    end

    // Main sequence.
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {trip_in, stop_in, start_b_in, start_a_in} = 4'h0;
        mode_a = 2'h0;
        mode_b = 2'h0;
        cyc(10);
        presetn <= 1'b1;
        // Reset values, clamping and an unmapped place.
        rd(`MSCS_ADDR_CTRL, 32'h0, 1'b0);
        rd(`MSCS_ADDR_DELAY, 32'h1, 1'b0);
        rd(`MSCS_ADDR_STATUS, 32'h0, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
        wr(`MSCS_ADDR_DELAY, 32'h0);
        rd(`MSCS_ADDR_DELAY, 32'h1, 1'b0);
        wr(`MSCS_ADDR_DELAY, 32'hFF);
        rd(`MSCS_ADDR_DELAY, 32'h7D, 1'b0);
        wr(`MSCS_ADDR_DELAY, 32'h1);
        rd(`MSCS_ADDR_CMD, 32'h0, 1'b0);
        // Non-reversing starter.
        pulse(4'h1); check(st(), 32'h1);
        pulse(4'h2); check(st(), 32'h1);
        wr(`MSCS_ADDR_CTRL, 32'h1); rd(`MSCS_ADDR_CTRL, 32'h0, 1'b0);
        pulse(4'h1); cyc(FBC + 15); check(st(), 32'h1);
        pulse(4'h4); check(st(), 32'h0);
        pulse(4'h1); pulse(4'h8); check(st(), 32'h0);
        pulse(4'h5); check(st(), 32'h0);
        mode_a <= 2'h1; pulse(4'h1); cyc(FBC + 15); check(st(), 32'h4);
        rd(`MSCS_ADDR_STATUS, 32'h2, 1'b0);
        wr(`MSCS_ADDR_CMD, 32'h8); mode_a <= 2'h2; pulse(4'h1); pulse(4'h4);
        cyc(FBC - 15); check(st(), 32'h0);
        cyc(30); check(st(), 32'h8);
        mode_a <= 2'h0; cyc(8); wr(`MSCS_ADDR_CMD, 32'h8); cyc(3); check(st(), 32'h0);
        // Bidirectional starter.
        wr(`MSCS_ADDR_CTRL, 32'h1); rd(`MSCS_ADDR_CTRL, 32'h1, 1'b0);
        pulse(4'h1); check(st(), 32'h1);
        pulse(4'h2); check(st(), 32'h0);
        wait_on(1'b1); check(st(), 32'h2);
        pulse(4'h1); check(st(), 32'h0);
        wait_on(1'b0); check(st(), 32'h1);
        pulse(4'h4); check(st(), 32'h0);
        mode_b <= 2'h1; pulse(4'h2); check(st(), 32'h2);
        cyc(FBC + 15); check(st(), 32'h4);
        mode_b <= 2'h2; wr(`MSCS_ADDR_CMD, 32'h8); pulse(4'h2); pulse(4'h8);
        cyc(FBC + 15); check(st(), 32'h8);
        mode_b <= 2'h0; cyc(8); wr(`MSCS_ADDR_CMD, 32'h8);
        // Two-speed starter, fast start inhibited, then allowed.
        wr(`MSCS_ADDR_CTRL, 32'h6); pulse(4'h2); check(st(), 32'h0);
        pulse(4'h1); check(st(), 32'h1);
        pulse(4'h2); check(st(), 32'h2);
        pulse(4'h1); check(st(), 32'h0);
        wait_on(1'b0); check(st(), 32'h1);
        pulse(4'h8); check(st(), 32'h0);
        mode_a <= 2'h1; pulse(4'h1); cyc(FBC + 15); check(st(), 32'h4);
        mode_a <= 2'h0; wr(`MSCS_ADDR_CMD, 32'h8);
        wr(`MSCS_ADDR_CTRL, 32'h2); pulse(4'h2); check(st(), 32'h2);
        mode_b <= 2'h2; cyc(8); pulse(4'h4); cyc(FBC + 15); check(st(), 32'h8);
        mode_b <= 2'h0; cyc(8); wr(`MSCS_ADDR_CMD, 32'h8);
        // Slip ring starter driven by bus commands; a bus start B is ignored there.
        wr(`MSCS_ADDR_CTRL, 32'h3); wr(`MSCS_ADDR_CMD, 32'h1); cyc(3); check(st(), 32'h1);
        wait_on(1'b1); check(st(), 32'h3);
        rd(`MSCS_ADDR_STATUS, 32'h14, 1'b0);
        wr(`MSCS_ADDR_CMD, 32'h2); cyc(3); check(st(), 32'h3);
        wr(`MSCS_ADDR_CMD, 32'h4); cyc(3); check(st(), 32'h0);
        complete_run();
    end
endmodule : mscs_core_tb
